// ### design/sst_core.sv
// Purpose: smart self-test execution and log sector access behind an axi4-lite task file
// Assumes: step_fail comes from mechanics logic on aclk; one write and one read at a time
// Notes:   logs are moved one 32-bit word per access of the data register
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "sst_params.svh"
// Operation
// R01: captive test holds busy until finished
// R02: status byte written before captive completion
// R03: error stops test, records, completes
// R04: off-line routine only in off-line mode
// R05: subcommand picks short test mode; two minutes
// R06: short test includes partial read scan
// R07: extended drops partial scan, adds full scan
// R08: selective scans host spans from log 09h
// R09: host sets rest-of-media flag in log 09h
// R10: log read signature B0/D5/C2/4F
// R11: log address and count from task file
// R12: unwritten host logs read as zero
// R13: directory, summary, comprehensive logs read-only
// R14: self-test log read-only, selective read/write
// R15: 80h-9Fh host logs, 16 sectors each
// R16: host avoids device vendor logs A0h-BFh
// R17: directory version word 01h, 512 bytes
// R18: directory byte 2n holds log n size
// R19: off-line run completes first, no busy
// R20: writes to read-only logs abort untouched
module sst_core #(
  parameter longint unsigned STEP_CYCLES = `SST_STEP_CYCLES  // cycles per test step
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [5:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [5:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 step_fail,
  output sst_pkg::sst_step_type     step_code,
  output logic                      busy
);

  // size in sectors of each log address
  function automatic logic [7:0] log_size(input logic [7:0] a);
    if (a == `SST_LOG_COMP_ERR) return `SST_SIZE_COMP_ERR;                          // R13
    if (a >= `SST_LOG_HOST_LO && a <= `SST_LOG_HOST_HI) return `SST_SIZE_HOST;      // R15
    if (a >= `SST_LOG_DVS96_LO && a <= `SST_LOG_DVS96_HI) return `SST_SIZE_DVS96;   // R16
    if (a <= `SST_LOG_SUM_ERR || a == `SST_LOG_SELFTEST || a == `SST_LOG_SELECTIVE)
      return 8'h01;                                                                 // R13
    if (a >= `SST_LOG_DVS_LO && a <= `SST_LOG_DVS_HI) return 8'h01;
    return 8'h00;                                                                   // R14
  endfunction

  // storage slot of a host-writable log
  function automatic logic [5:0] log_slot(input logic [7:0] a);
    return (a == `SST_LOG_SELECTIVE) ? `SST_SEL_SLOT : a[5:0];
  endfunction

  // first step of each routine
  function automatic sst_pkg::sst_step_type first_step(input sst_pkg::sst_kind_type k);
    return (k == sst_pkg::RK_OFFLINE) ? sst_pkg::SP_RRER_SCAN : sst_pkg::SP_READ;   // R04
  endfunction

  // step sequencing per routine
  function automatic sst_pkg::sst_step_type next_step(input sst_pkg::sst_kind_type k,
                                                      input sst_pkg::sst_step_type s,
                                                      input logic rest);
    case (s)
      sst_pkg::SP_READ:      return sst_pkg::SP_WRITE;
      sst_pkg::SP_WRITE:     return sst_pkg::SP_SERVO;
      sst_pkg::SP_SERVO:     return (k == sst_pkg::RK_SHORT) ? sst_pkg::SP_PART_SCAN   // R06
                                                             : sst_pkg::SP_RAND_READ;  // R07
      sst_pkg::SP_PART_SCAN: return sst_pkg::SP_RAND_READ;
      sst_pkg::SP_RAND_READ: return sst_pkg::SP_RAM;
      sst_pkg::SP_RAM:       return sst_pkg::SP_PARAM;
      sst_pkg::SP_PARAM:     return sst_pkg::SP_ERRLOG;
      sst_pkg::SP_ERRLOG:    return (k == sst_pkg::RK_EXT) ? sst_pkg::SP_FULL_SCAN     // R07
                                  : (k == sst_pkg::RK_SEL) ? sst_pkg::SP_SPAN_SCAN     // R08
                                  : sst_pkg::SP_NONE;
      sst_pkg::SP_SPAN_SCAN: return rest ? sst_pkg::SP_REST_SCAN : sst_pkg::SP_NONE;   // R09
      sst_pkg::SP_RRER_SCAN: return sst_pkg::SP_REALLOC_SCAN;                          // R04
      default:               return sst_pkg::SP_NONE;
    endcase
  endfunction

  sst_pkg::sst_taskfile_type tf_q;       // task file bytes
  sst_pkg::sst_phase_type    phase_q;    // host-side command phase
  sst_pkg::sst_kind_type     kind_q;     // routine kind
  sst_pkg::sst_step_type     step_q;     // current step, none when idle
  logic [31:0] step_cnt_q;               // cycles in current step
  logic        fin_q;                    // runner just wrote its result
  logic [7:0]  test_sts_q;               // self-test execution status byte
  logic        err_q;                    // error bit of status
  logic        abrt_q;                   // aborted-command bit of error
  logic        rest_flag_q;              // selective rest-of-media scan flag
  logic [7:0]  log_q;                    // log being moved
  logic [7:0]  sec_q;                    // sector within log
  logic [6:0]  word_q;                   // word within sector
  logic [7:0]  left_q;                   // sectors still to move
  logic        aw_hold_q;
  logic [5:0]  aw_addr_q;
  logic        w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [31:0] store_rd;                 // store read word

  localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 64'd1);

  // write channel decode
  wire        wr_fire   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire        wr_mapped = (aw_addr_q <= `SST_OFS_LAST) && (aw_addr_q[1:0] == 2'b00);
  wire [7:0]  wbyte     = w_data_q[7:0];
  wire        wb_ok     = wr_fire && wr_mapped && w_strb_q[0];
  wire        tf_open   = (phase_q == sst_pkg::CP_IDLE);
  wire        cmd_go    = wb_ok && (aw_addr_q == `SST_OFS_CMD) && tf_open &&
                          (tf_q.dev[`SST_DEV_DRV] == 1'b0);
  wire        smart_sig = (wbyte == `SST_CMD_SMART) && (tf_q.cyl_hi == `SST_CYL_HI_KEY) &&
                          (tf_q.cyl_lo == `SST_CYL_LO_KEY);                       // R10
  wire [7:0]  req_size  = log_size(tf_q.snum);                                    // R11
  wire        cnt_ok    = (tf_q.scnt != 8'h00) && (tf_q.scnt <= req_size);
  wire        wr_able   = (tf_q.snum == `SST_LOG_SELECTIVE) ||
                          (tf_q.snum >= `SST_LOG_HOST_LO && tf_q.snum <= `SST_LOG_HOST_HI);
  wire        go_rd_log = cmd_go && smart_sig && (tf_q.feat == `SST_FEAT_RD_LOG) && cnt_ok;
  wire        go_wr_log = cmd_go && smart_sig && (tf_q.feat == `SST_FEAT_WR_LOG) && cnt_ok && wr_able;
  wire        is_exec   = cmd_go && smart_sig && (tf_q.feat == `SST_FEAT_EXEC);
  wire [7:0]  sub       = tf_q.snum;                                              // R05
  wire        sub_off   = (sub == `SST_SUB_OFFLINE) || (sub == `SST_SUB_SHORT_OFF) ||
                          (sub == `SST_SUB_EXT_OFF) || (sub == `SST_SUB_SEL_OFF);
  wire        sub_cap   = (sub == `SST_SUB_SHORT_CAP) || (sub == `SST_SUB_EXT_CAP) ||
                          (sub == `SST_SUB_SEL_CAP);
  wire        start_run = is_exec && (sub_off || sub_cap);
  wire        stop_run  = is_exec && (sub == `SST_SUB_ABORT);
  wire        cmd_bad   = cmd_go && !go_rd_log && !go_wr_log && !start_run && !stop_run; // R20
  wire        data_wr   = wb_ok && (aw_addr_q == `SST_OFS_DATA) && (phase_q == sst_pkg::CP_LOG_OUT);
  wire sst_pkg::sst_kind_type new_kind =
      (sub[2:0] == 3'h1) ? sst_pkg::RK_SHORT :
      (sub[2:0] == 3'h2) ? sst_pkg::RK_EXT   :
      (sub[2:0] == 3'h4) ? sst_pkg::RK_SEL   : sst_pkg::RK_OFFLINE;

  // read channel decode
  wire        rd_fire   = s_axi_arvalid && s_axi_arready;
  wire        rd_mapped = (s_axi_araddr <= `SST_OFS_LAST) && (s_axi_araddr[1:0] == 2'b00);
  wire        data_rd   = rd_fire && (s_axi_araddr == `SST_OFS_DATA) && (phase_q == sst_pkg::CP_LOG_IN);
  wire        word_last = (word_q == 7'h7F);
  wire        xfer_step = data_rd || data_wr;

  // directory word: byte 2n holds size of log n, bytes 0-1 hold the version
  wire [7:0]  dir_even  = (word_q == 7'h00) ? `SST_LOG_VERSION : log_size({word_q, 1'b0}); // R17
  wire [7:0]  dir_odd   = log_size({word_q, 1'b1});                                         // R18
  wire [31:0] dir_word  = (sec_q == 8'h00) ? {8'h00, dir_odd, 8'h00, dir_even} : 32'h0000_0000;
  wire        log_host  = (log_q == `SST_LOG_SELECTIVE) ||
                          (log_q >= `SST_LOG_HOST_LO && log_q <= `SST_LOG_HOST_HI);
  wire [31:0] log_word  = (log_q == `SST_LOG_DIR) ? dir_word :
                          log_host ? store_rd : 32'h0000_0000;                    // R13 R14
  wire [16:0] store_addr = {log_slot(log_q), sec_q[3:0], word_q};

  // step runner events
  wire        run_on    = (step_q != sst_pkg::SP_NONE);
  wire        step_end  = run_on && (step_cnt_q == STEP_LAST);
  wire sst_pkg::sst_step_type step_nx = next_step(kind_q, step_q, rest_flag_q);
  wire        run_done  = step_end && (step_nx == sst_pkg::SP_NONE);

  // storage for writable logs
  sst_log_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (data_wr),
    .wr_addr (store_addr),
    .wr_data (w_data_q),
    .rd_addr (store_addr),
    .rd_data (store_rd)
  );

  // axi write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 6'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // axi write ready and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
      s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;  // slverr on unmapped
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read: data latched at address handshake, answered next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_mapped ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          `SST_OFS_SCNT:     s_axi_rdata <= {24'h00_0000, tf_q.scnt};
          `SST_OFS_SNUM:     s_axi_rdata <= {24'h00_0000, tf_q.snum};
          `SST_OFS_CYL_LO:   s_axi_rdata <= {24'h00_0000, tf_q.cyl_lo};
          `SST_OFS_CYL_HI:   s_axi_rdata <= {24'h00_0000, tf_q.cyl_hi};
          `SST_OFS_DEV:      s_axi_rdata <= {24'h00_0000, tf_q.dev};
          `SST_OFS_STATUS:   s_axi_rdata <= {24'h00_0000, busy, 1'b1, 2'b00,
                                             (phase_q == sst_pkg::CP_LOG_IN) ||
                                             (phase_q == sst_pkg::CP_LOG_OUT), 2'b00,
                                             err_q};                            // R19
          `SST_OFS_ERROR:    s_axi_rdata <= {29'h0000_0000, abrt_q, 2'b00};
          `SST_OFS_DATA:     s_axi_rdata <= data_rd ? log_word : 32'h0000_0000;
          `SST_OFS_TEST_STS: s_axi_rdata <= {24'h00_0000, test_sts_q};
          default:           s_axi_rdata <= 32'h0000_0000;  // write-only and unmapped
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // task file bytes, writable only while no command is in progress
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf_q <= '0;
    end else if (wb_ok && tf_open) begin
      case (aw_addr_q)
        `SST_OFS_FEAT:   tf_q.feat   <= wbyte;
        `SST_OFS_SCNT:   tf_q.scnt   <= wbyte;
        `SST_OFS_SNUM:   tf_q.snum   <= wbyte;
        `SST_OFS_CYL_LO: tf_q.cyl_lo <= wbyte;
        `SST_OFS_CYL_HI: tf_q.cyl_hi <= wbyte;
        `SST_OFS_DEV:    tf_q.dev    <= wbyte;
        default:         tf_q        <= tf_q;
      endcase
    end
  end

  // command phase, log pointers and error reporting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= sst_pkg::CP_IDLE;
      err_q   <= 1'b0;
      abrt_q  <= 1'b0;
      log_q   <= 8'h00;
      sec_q   <= 8'h00;
      word_q  <= 7'h00;
      left_q  <= 8'h00;
    end else begin
      if (cmd_go) begin
        err_q  <= cmd_bad;                                   // R20
        abrt_q <= cmd_bad;
        log_q  <= tf_q.snum;                                 // R11
        sec_q  <= 8'h00;
        word_q <= 7'h00;
        left_q <= tf_q.scnt;                                 // R11
      end
      case (phase_q)
        sst_pkg::CP_IDLE: begin
          if (go_rd_log) begin
            phase_q <= sst_pkg::CP_LOG_IN;
          end else if (go_wr_log) begin
            phase_q <= sst_pkg::CP_LOG_OUT;
          end else if (start_run && sub_cap) begin
            phase_q <= sst_pkg::CP_CAPTIVE;                  // R01
          end
        end
        sst_pkg::CP_CAPTIVE: begin
          if (fin_q) begin
            phase_q <= sst_pkg::CP_IDLE;                     // R02 R03
            err_q   <= (test_sts_q == `SST_TS_FAIL);
          end
        end
        sst_pkg::CP_LOG_IN, sst_pkg::CP_LOG_OUT: begin
          if (xfer_step) begin
            word_q <= word_q + 7'h01;
            if (word_last) begin
              sec_q  <= sec_q + 8'h01;
              left_q <= left_q - 8'h01;
              if (left_q == 8'h01) begin
                phase_q <= sst_pkg::CP_IDLE;
              end
            end
          end
        end
        default: phase_q <= sst_pkg::CP_IDLE;
      endcase
    end
  end

  // selective log rest-of-media flag shadow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rest_flag_q <= 1'b0;
    end else if (data_wr && (log_q == `SST_LOG_SELECTIVE) && (word_q == `SST_SEL_FLAG_WORD)) begin
      rest_flag_q <= w_data_q[`SST_SEL_FLAG_BIT];            // R09
    end
  end

  // routine runner: steps, failure stop and result byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_q     <= sst_pkg::RK_OFFLINE;
      step_q     <= sst_pkg::SP_NONE;
      step_cnt_q <= 32'h0000_0000;
      fin_q      <= 1'b0;
      test_sts_q <= `SST_TS_PASS;
    end else begin
      fin_q <= 1'b0;
      if (start_run) begin
        kind_q     <= new_kind;                              // R05
        step_q     <= first_step(new_kind);                  // R04
        step_cnt_q <= 32'h0000_0000;
        test_sts_q <= `SST_TS_RUNNING;
      end else if (stop_run) begin
        step_q <= sst_pkg::SP_NONE;
        if (run_on) begin
          test_sts_q <= `SST_TS_ABORTED;
        end
      end else if (run_on && step_fail) begin
        step_q     <= sst_pkg::SP_NONE;                      // R03
        test_sts_q <= `SST_TS_FAIL;                          // R03
        fin_q      <= 1'b1;
      end else if (run_done) begin
        step_q     <= sst_pkg::SP_NONE;
        test_sts_q <= `SST_TS_PASS;                          // R02
        fin_q      <= 1'b1;
      end else if (step_end) begin
        step_q     <= step_nx;                               // R06 R07 R08
        step_cnt_q <= 32'h0000_0000;
      end else if (run_on) begin
        step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
    end
  end

  // registered outputs toward the mechanics and the host
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_code <= sst_pkg::SP_NONE;
      busy      <= 1'b0;
    end else begin
      step_code <= step_q;
      busy      <= (start_run && sub_cap) || ((phase_q == sst_pkg::CP_CAPTIVE) && !fin_q); // R01 R19
    end
  end

endmodule

// ### design/sst_params.svh
// Purpose: offsets, field positions, codes and timing counts of the smart self-test and log block
// Assumes: 32-bit axi4-lite data, one register per aligned word
// Notes:   definitions only
`ifndef SST_PARAMS_SVH
`define SST_PARAMS_SVH

// register byte offsets
`define SST_OFS_CMD        6'h00
`define SST_OFS_FEAT       6'h04
`define SST_OFS_SCNT       6'h08
`define SST_OFS_SNUM       6'h0C
`define SST_OFS_CYL_LO     6'h10
`define SST_OFS_CYL_HI     6'h14
`define SST_OFS_DEV        6'h18
`define SST_OFS_STATUS     6'h1C
`define SST_OFS_ERROR      6'h20
`define SST_OFS_DATA       6'h24
`define SST_OFS_TEST_STS   6'h28
`define SST_OFS_LAST       6'h28

// status, error and device bit positions
`define SST_STS_BSY        7
`define SST_STS_DRDY       6
`define SST_STS_DRQ        3
`define SST_STS_ERR        0
`define SST_ERR_ABRT       2
`define SST_DEV_DRV        4

// command signature
`define SST_CMD_SMART      8'hB0
`define SST_CYL_HI_KEY     8'hC2
`define SST_CYL_LO_KEY     8'h4F
`define SST_FEAT_EXEC      8'hD4
`define SST_FEAT_RD_LOG    8'hD5
`define SST_FEAT_WR_LOG    8'hD6

// execute subcommands
`define SST_SUB_OFFLINE    8'h00
`define SST_SUB_SHORT_OFF  8'h01
`define SST_SUB_EXT_OFF    8'h02
`define SST_SUB_SEL_OFF    8'h04
`define SST_SUB_ABORT      8'h7F
`define SST_SUB_SHORT_CAP  8'h81
`define SST_SUB_EXT_CAP    8'h82
`define SST_SUB_SEL_CAP    8'h84

// log addresses and sizes
`define SST_LOG_DIR        8'h00
`define SST_LOG_SUM_ERR    8'h01
`define SST_LOG_COMP_ERR   8'h02
`define SST_LOG_SELFTEST   8'h06
`define SST_LOG_SELECTIVE  8'h09
`define SST_LOG_HOST_LO    8'h80
`define SST_LOG_HOST_HI    8'h9F
`define SST_LOG_DVS_LO     8'hA0
`define SST_LOG_DVS96_LO   8'hA1
`define SST_LOG_DVS96_HI   8'hA2
`define SST_LOG_DVS_HI     8'hBF
`define SST_SIZE_COMP_ERR  8'h33
`define SST_SIZE_HOST      8'h10
`define SST_SIZE_DVS96     8'h60
`define SST_LOG_VERSION    8'h01
`define SST_SEL_SLOT       6'h20
`define SST_WORDS_PER_SEC  8'h80
`define SST_LOG_WORDS      67584
`define SST_SEL_FLAG_WORD  7'h7C
`define SST_SEL_FLAG_BIT   1

// self-test execution status byte values
`define SST_TS_PASS        8'h00
`define SST_TS_ABORTED     8'h10
`define SST_TS_FAIL        8'h70
`define SST_TS_RUNNING     8'hF0

// timing: short test takes about two minutes over eight steps
`define SST_CLK_HZ         64'd200_000_000
`define SST_SHORT_TEST_S   64'd120
`define SST_SHORT_STEPS    64'd8
`define SST_STEP_CYCLES    (`SST_SHORT_TEST_S * `SST_CLK_HZ / `SST_SHORT_STEPS)

`endif

// ### design/sst_pkg.sv
// Purpose: types shared by the smart self-test and log block
// Assumes: nothing beyond the params header
// Notes:   constants live in sst_params.svh
package sst_pkg;

  // task file as written by software
  typedef struct packed {
    logic [7:0] feat;    // subcommand select
    logic [7:0] scnt;    // sector count
    logic [7:0] snum;    // sector number / log address
    logic [7:0] cyl_lo;  // signature low
    logic [7:0] cyl_hi;  // signature high
    logic [7:0] dev;     // drive/head select
  } sst_taskfile_type;

  // command phase of the host interface
  typedef enum logic [1:0] {CP_IDLE, CP_CAPTIVE, CP_LOG_IN, CP_LOG_OUT} sst_phase_type;

  // kind of routine being run
  typedef enum logic [1:0] {RK_OFFLINE, RK_SHORT, RK_EXT, RK_SEL} sst_kind_type;

  // step presented to the mechanics
  typedef enum logic [3:0] {
    SP_NONE, SP_READ, SP_WRITE, SP_SERVO, SP_PART_SCAN, SP_RAND_READ, SP_RAM,
    SP_PARAM, SP_ERRLOG, SP_FULL_SCAN, SP_SPAN_SCAN, SP_REST_SCAN, SP_RRER_SCAN,
    SP_REALLOC_SCAN
  } sst_step_type;

endpackage

// ### design/sst_log_store.sv
// Purpose: storage for the host-writable log sectors
// Assumes: address = {slot[5:0], sector[3:0], word[6:0]}, slot 32 is the selective log
// Notes:   one-cycle read latency; unwritten sectors read as zero
`timescale 1ns/10ps
`include "sst_params.svh"
module sst_log_store (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wr_en,
  input  wire logic [16:0] wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [16:0] rd_addr,
  output logic      [31:0] rd_data
);

  logic [31:0] mem [0:`SST_LOG_WORDS-1];  // sector words
  logic [1023:0] written_q;               // one flag per sector

  // flags cleared on reset so untouched sectors read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      written_q <= '0;
    end else if (wr_en) begin
      written_q[wr_addr[16:7]] <= 1'b1;
    end
  end

  // word array, no reset
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read with zero for never-written sectors
  always_ff @(posedge aclk) begin
    rd_data <= written_q[rd_addr[16:7]] ? mem[rd_addr] : 32'h0000_0000; // R12
  end

endmodule

// ### bench/sst_core_chk.sv
// Purpose: handshake and busy checks on the self-test block ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound into every core instance
`timescale 1ns/10ps
module sst_core_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       step_fail,
  input wire logic       busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_held: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during response");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid after handshake");
  a_aw_back: assert property (s_axi_bvalid && s_axi_bready |=> ##[0:2] s_axi_awready)
    else $error("awready not back");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid after handshake");
  a_ar_back: assert property (s_axi_rvalid && s_axi_rready |=> ##[0:2] s_axi_arready)
    else $error("arready not back");
  a_busy_resp: assert property ($rose(busy) |-> s_axi_bvalid)
    else $error("busy without command answer");
  a_fail_stop: assert property (busy && step_fail |-> ##[1:3] !busy)
    else $error("failed test kept busy");
endmodule
bind sst_core sst_core_chk sst_core_chk_i (.*);

// ### bench/sst_mech_model.sv
// Purpose: mechanics stand-in reporting a failed step
// Assumes: step_code registered on aclk
// Notes:   fails only the full scan step, when armed
`timescale 1ns/10ps
module sst_mech_model (
  input  wire logic                  aclk,
  input  wire logic                  fail_en,
  input  wire sst_pkg::sst_step_type step_code,
  output logic                       step_fail
);
  initial step_fail = 1'b0;
  // fault level follows the armed scan step
  always @(posedge aclk) step_fail <= fail_en && step_code == sst_pkg::SP_FULL_SCAN;
endmodule

// ### bench/test_sst_core.sv
// Purpose: self-checking bench for the self-test and log block
// Assumes: bready and rready held high, full strobes
// Notes:   four-cycle steps keep routines short
`timescale 1ns/10ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("Error %s %h %h", nm, e, a); end end
module test_sst_core;
  logic                  aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, fen = 0;
  logic [5:0]            awa = 0, ara = 0;
  logic [31:0]           wd = 0, v;
  logic [1:0]            rs;
  logic [15:0]           seen;
  wire  [31:0]           rdt;
  wire  [1:0]            br, rr;
  wire                   awr, wrd, bv, arr, rv, sf, bsy;
  sst_pkg::sst_step_type sc;
  int                    n_fail = 0, check_count = 0;
  wire  [3:0]            hs = {bsy, rv, arr, bv};
  initial forever #2.5 aclk = ~aclk;
  sst_core #(.STEP_CYCLES(4)) sst_core_i (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .step_fail(sf), .step_code(sc), .busy(bsy));
  sst_mech_model sst_mech_model_i (.aclk, .fail_en(fen), .step_code(sc), .step_fail(sf));
  always @(posedge aclk) seen[sc] <= 1'b1;
  task automatic results;
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait for one handshake or busy line to reach a level
  task automatic wt(input int k, input logic e);
    int n = 0;
    do @(posedge aclk); while (hs[k] !== e && ++n < 500);
    if (n == 500) begin
      n_fail++;
      results;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    {awa, wd, awv, wv} <= {a, d, 2'b11};
    for (int n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if ((awr || !awv) && (wrd || !wv)) break;
    end
    wt(0, 1'b1);
    rs = br;
  endtask
  task automatic rd(input logic [5:0] a);
    {ara, arv} <= {a, 1'b1};
    wt(1, 1'b1);
    arv <= 1'b0;
    wt(2, 1'b1);
    {v, rs} = {rdt, rr};
  endtask
  task automatic cmd(input logic [7:0] f, s, c);
    wr(6'h04, 32'(f));
    wr(6'h08, 32'(c));
    wr(6'h0C, 32'(s));
    wr(6'h10, 32'h0000_004F);
    wr(6'h14, 32'h0000_00C2);
    wr(6'h00, 32'h0000_00B0);
  endtask
  task automatic t_dir;
    cmd(8'hD5, 8'h00, 8'h01);
    for (int i = 0; i < 128; i++) begin
      rd(6'h24);
      case (i)
        0: `CHK("ver", 32'h0001_0001, v)
        1: `CHK("comp", 32'h0000_0033, v)
        2: `CHK("rsv", 32'h0000_0000, v)
        4: `CHK("sel", 32'h0001_0000, v)
        64: `CHK("host", 32'h0010_0010, v)
        80: `CHK("dvs", 32'h0060_0001, v)
      endcase
    end
  endtask
  task automatic t_host;
    cmd(8'hD6, 8'h80, 8'h01);
    for (int i = 0; i < 128; i++) wr(6'h24, 32'hA5A5_0000 + 32'(i));
    cmd(8'hD5, 8'h80, 8'h02);
    for (int i = 0; i < 256; i++) begin
      rd(6'h24);
      `CHK("hlog", (i < 128) ? 32'hA5A5_0000 + 32'(i) : 32'h0000_0000, v)
    end
  endtask
  task automatic t_exec(input logic [7:0] sub, ts, input sst_pkg::sst_step_type st);
    seen = '0;
    cmd(8'hD4, sub, 8'h00);
    @(posedge aclk);
    `CHK("busy", sub[7], bsy)
    wt(3, 1'b0);
    repeat (40) @(posedge aclk);
    rd(6'h28);
    `CHK("tsts", 32'(ts), v)
    `CHK("step", 1'b1, seen[st])
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(6'h1C);
    `CHK("status", 32'h0000_0040, v)
    rd(6'h2C);
    `CHK("unmapped", 2'b10, rs)
    wr(6'h2C, 32'h0000_0000);
    `CHK("wresp", 2'b10, rs)
    t_dir;
    t_host;
    foreach (seen[i]) if (i < 4) begin
      cmd(8'hD6, 8'(i * 2), 8'h01);
      rd(6'h20);
      `CHK("abort", 32'h0000_0004, v)
    end
    t_exec(8'h81, 8'h00, sst_pkg::SP_PART_SCAN);
    t_exec(8'h02, 8'h00, sst_pkg::SP_FULL_SCAN);
    `CHK("nopart", 1'b0, seen[sst_pkg::SP_PART_SCAN])
    t_exec(8'h00, 8'h00, sst_pkg::SP_REALLOC_SCAN);
    cmd(8'hD6, 8'h09, 8'h01);
    for (int i = 0; i < 128; i++) wr(6'h24, 32'(i == 124) << 1);
    t_exec(8'h84, 8'h00, sst_pkg::SP_REST_SCAN);
    fen <= 1'b1;
    t_exec(8'h82, 8'h70, sst_pkg::SP_FULL_SCAN);
    results;
  end
endmodule
